// ### design/tecfd_pkg.sv
// Purpose: constants and types for the dual timer/event counter with frequency divider
// Assumes: 100 MHz clock_in, Avalon-MM register slave with 32-bit words
// Notes: registers hold narrow data in the low bits, upper bits read as zero
// Contract
// (RULE1) Control bit 4 runs or stops counter
// (RULE2) Timer mode increments once per internal clock
// (RULE3) Overflow raises request, reloads, keeps counting
// (RULE4) Interrupt passes only when enable bit set
// (RULE5) Narrow bits 7:6 choose counting mode
// (RULE6) Event counting bypasses the prescaler
// (RULE7) Edge select 0 rising, 1 falling
// (RULE8) Event counting continues powered down, wakes
// (RULE9) Narrow prescaled clock; wide sub or div4
// (RULE10) Pulse mode armed, waits for active edge
// (RULE11) Pulse start/stop edges; stop clears enable
// (RULE12) Timer/event modes never self-clear enable
// (RULE13) After pulse, hold count, ignore pin
// (RULE14) Pulse mode reacts to transitions only
// (RULE15) Divider output toggles on each overflow
// (RULE16) Divider source chosen by select bit
// (RULE17) Divider disabled leaves pin plain I/O
// (RULE18) Divider reaches pin only as output
// (RULE19) Port data bit gates divider output
// (RULE20) Prescale 000 /1, 001 /2, 010 /4
// (RULE21) Prescale 011..111 divide 8 to 128
// (RULE22) Source select 0 narrow, 1 wide
// (RULE23) Preload loads at once only when stopped
// (RULE24) Overflow at 8-bit or 16-bit all ones
// (RULE25) Inputs two-stage synchronised, edge detected
package tecfd_pkg;
    localparam logic [3:0] ADDR_NARROW_CTRL = 4'h0;
    localparam logic [3:0] ADDR_NARROW_PRELOAD = 4'h1;
    localparam logic [3:0] ADDR_NARROW_COUNT = 4'h2;
    localparam logic [3:0] ADDR_WIDE_CTRL = 4'h3;
    localparam logic [3:0] ADDR_WIDE_PRELOAD = 4'h4;
    localparam logic [3:0] ADDR_WIDE_COUNT = 4'h5;
    localparam logic [3:0] ADDR_INT_CTRL = 4'h6;
    localparam logic [3:0] ADDR_MISC = 4'h7;
    localparam logic [3:0] ADDR_PORT_A = 4'h8;
    localparam logic [3:0] ADDR_POWER = 4'h9;
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int WIDE_CLK_SEL_BIT = 5;
    localparam int ENABLE_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int INT_NARROW_EN_BIT = 0;
    localparam int INT_WIDE_EN_BIT = 1;
    localparam int INT_NARROW_REQ_BIT = 2;
    localparam int INT_WIDE_REQ_BIT = 3;
    localparam int MISC_FD_EN_BIT = 0;
    localparam int MISC_FD_SEL_BIT = 1;
    localparam int PORT_BIT5 = 5;
    localparam logic [7:0] NARROW_CTRL_RESET = 8'h08;
    localparam logic [7:0] WIDE_CTRL_RESET = 8'h08;
    localparam logic [7:0] NARROW_CTRL_MASK = 8'hdf;
    localparam logic [7:0] WIDE_CTRL_MASK = 8'hf8;
    localparam logic [7:0] NARROW_FULL = 8'hff;
    localparam logic [15:0] WIDE_FULL = 16'hffff;
    localparam logic [1:0] MODE_EVENT_CMP = 2'b00;
    localparam logic [1:0] MODE_EVENT_PIN = 2'b01;
    localparam logic [1:0] MODE_TIMER = 2'b10;
    localparam logic [1:0] MODE_PULSE = 2'b11;
    localparam logic [1:0] SYS_DIV4_COUNT = 2'h3;
    localparam int SUB_CLK_HZ = 32768;
    localparam int CLK_HZ = 100000000;
    localparam int SUB_DIV_CYCLES = CLK_HZ / SUB_CLK_HZ;
    typedef enum logic [2:0] {
        TECFD_IDLE = 3'b001,
        TECFD_RUN = 3'b010,
        TECFD_ARMED = 3'b100
    } tecfd_state_e;
endpackage

// ### design/tecfd_ctr_if.sv
// Purpose: connection between top level and one counter unit
// Assumes: single clock domain
// Notes: control fields are decoded in the top level
`timescale 1ns/1ps
`default_nettype none
interface tecfd_ctr_if;
    logic [1:0] mode;
    logic enable;
    logic edge_sel;
    logic tick;
    logic ev_src;
    logic pin_src;
    logic [15:0] preload;
    logic preload_wr;
    logic [15:0] count;
    logic overflow;
    logic stop_clr;
    modport top (output mode, enable, edge_sel, tick, ev_src, pin_src, preload, preload_wr,
                 input count, overflow, stop_clr);
    modport unit (input mode, enable, edge_sel, tick, ev_src, pin_src, preload, preload_wr,
                  output count, overflow, stop_clr);
endinterface
`default_nettype wire

// ### design/tecfd_counter.sv
// Purpose: one timer/event counter unit, width set by parameter
// Assumes: sources already synchronised; tick is a one-cycle enable
// Notes: count reads back zero-extended to 16 bits
`timescale 1ns/1ps
`default_nettype none
module tecfd_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clock_in,          // system clock
    input wire logic sys_rst_in,        // synchronous reset
    tecfd_ctr_if.unit bus               // control and status
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic ev_q;
        logic pin_q;
        logic ovf;
        logic stop;
        tecfd_pkg::tecfd_state_e st;
    } tecfd_cnt_s;
    tecfd_cnt_s s_q, s_d;
    logic ev_rise, ev_fall, pin_rise, pin_fall, step, ev_hit, start_hit, stop_hit;
    logic [WIDTH-1:0] full, pre;
    always_comb begin
        full = {WIDTH{1'b1}};
        pre = bus.preload[WIDTH-1:0];
        ev_rise = bus.ev_src & ~s_q.ev_q;  // RULE25
        ev_fall = ~bus.ev_src & s_q.ev_q;
        pin_rise = bus.pin_src & ~s_q.pin_q;
        pin_fall = ~bus.pin_src & s_q.pin_q;
        ev_hit = bus.edge_sel ? ev_fall : ev_rise;  // RULE7
        start_hit = bus.edge_sel ? pin_rise : pin_fall;  // RULE11 RULE14
        stop_hit = bus.edge_sel ? pin_fall : pin_rise;
        s_d = s_q;
        s_d.ev_q = bus.ev_src;
        s_d.pin_q = bus.pin_src;
        s_d.ovf = 1'b0;
        s_d.stop = 1'b0;
        step = 1'b0;
        case (s_q.st)
            tecfd_pkg::TECFD_IDLE: begin
                if (bus.enable && !s_q.stop) begin  // RULE1
                    s_d.st = (bus.mode == tecfd_pkg::MODE_PULSE) ? tecfd_pkg::TECFD_ARMED : tecfd_pkg::TECFD_RUN;  // RULE10
                end
            end
            tecfd_pkg::TECFD_ARMED: begin
                if (!bus.enable || bus.mode != tecfd_pkg::MODE_PULSE) begin
                    s_d.st = tecfd_pkg::TECFD_IDLE;
                end else if (start_hit) begin
                    s_d.st = tecfd_pkg::TECFD_RUN;
                end
            end
            tecfd_pkg::TECFD_RUN: begin
                if (!bus.enable) begin  // RULE1 RULE13
                    s_d.st = tecfd_pkg::TECFD_IDLE;
                end else if (bus.mode == tecfd_pkg::MODE_PULSE) begin
                    if (stop_hit) begin
                        s_d.st = tecfd_pkg::TECFD_IDLE;
                        s_d.stop = 1'b1;  // RULE11
                    end else begin
                        step = bus.tick;  // RULE9
                    end
                end else if (bus.mode == tecfd_pkg::MODE_TIMER) begin
                    step = bus.tick;  // RULE2 RULE9 RULE12
                end else begin
                    step = ev_hit;  // RULE6 RULE8 RULE12
                end
            end
            default: begin
                s_d.st = tecfd_pkg::TECFD_IDLE;
            end
        endcase
        if (step) begin
            if (s_q.count == full) begin  // RULE24
                s_d.count = pre;  // RULE3
                s_d.ovf = 1'b1;
            end else begin
                s_d.count = s_q.count + 1'b1;
            end
        end
        // Writes while running are kept in the preload and wait for the reload
        if (bus.preload_wr && s_q.st == tecfd_pkg::TECFD_IDLE && !bus.enable) begin
            s_d.count = pre;  // RULE23
        end
        if (sys_rst_in) begin
            s_d = '0;
            s_d.st = tecfd_pkg::TECFD_IDLE;
        end
    end
    always_ff @(posedge clock_in) begin
        s_q <= s_d;
    end
    assign bus.count = 16'(s_q.count);
    assign bus.overflow = s_q.ovf;
    assign bus.stop_clr = s_q.stop;
endmodule
`default_nettype wire

// ### design/tecfd_top.sv
// Purpose: two timer/event counters with a frequency divider output, Avalon-MM slave
// Assumes: pins arrive raw and are synchronised here; one 100 MHz clock
// Notes: one read or write completes in two cycles; waitrequest low in the second
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tecfd_top (
    input wire logic clock_in,                 // system clock
    input wire logic sys_rst_in,               // synchronous reset, high
    input wire logic [3:0] avs_address_in,     // word address
    input wire logic avs_read_in,              // read request
    input wire logic avs_write_in,             // write request
    input wire logic [31:0] avs_writedata_in,  // write data
    input wire logic [3:0] avs_byteenable_in,  // byte lanes
    output logic [31:0] avs_readdata_out,      // read data
    output logic avs_waitrequest_out,          // stall
    input wire logic comparator_one_output_in, // narrow event source
    input wire logic comparator_two_output_in, // wide event source
    input wire logic narrow_count_input_pin_in,// narrow pin
    input wire logic wide_count_input_pin_in,  // wide pin
    input wire logic port_a_bit5_pin_in,       // shared pin level
    output logic freq_divider_output_out,      // shared pin drive
    output logic freq_divider_output_oe_out,   // shared pin enable
    output logic narrow_irq_out,               // narrow interrupt
    output logic wide_irq_out,                 // wide interrupt
    output logic wakeup_out                    // wake-up pulse
);
    typedef struct packed {
        logic [7:0] nctl;
        logic [7:0] wctl;
        logic [7:0] npre;
        logic [15:0] wpre;
        logic [3:0] intc;
        logic [1:0] misc;
        logic pdir5;
        logic pdat5;
        logic pdown;
        logic [6:0] psc;
        logic [1:0] div4;
        logic [11:0] subc;
        logic fd;
        logic [31:0] rdata;
        logic ack;
        logic [4:0] s1;
        logic [4:0] s2;
        logic pin5;
        logic nirq;
        logic wirq;
        logic wake;
        logic pout;
        logic poe;
        logic nwr;
        logic wwr;
    } tecfd_top_s;
    tecfd_top_s r_q, r_d;
    tecfd_ctr_if nif();
    tecfd_ctr_if wif();
    logic [6:0] psc_next;
    logic ntick, sub_tick, sysdiv_tick, wr, rd, ovf_sel, nreq, wreq;
    logic [7:0] ctl_w;
    logic [15:0] pre_w;
    tecfd_counter #(.WIDTH(8)) u_narrow (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .bus(nif)
    );
    tecfd_counter #(.WIDTH(16)) u_wide (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .bus(wif)
    );
    assign nif.mode = r_q.nctl[tecfd_pkg::MODE_HI_BIT:tecfd_pkg::MODE_LO_BIT];  // RULE5
    assign nif.enable = r_q.nctl[tecfd_pkg::ENABLE_BIT];
    assign nif.edge_sel = r_q.nctl[tecfd_pkg::EDGE_BIT];
    assign nif.tick = ntick;
    assign nif.ev_src = (nif.mode == tecfd_pkg::MODE_EVENT_CMP) ? r_q.s2[0] : r_q.s2[2];
    assign nif.pin_src = r_q.s2[2];
    assign nif.preload = {8'h00, r_q.npre};
    assign nif.preload_wr = r_q.nwr;
    assign wif.mode = r_q.wctl[tecfd_pkg::MODE_HI_BIT:tecfd_pkg::MODE_LO_BIT];
    assign wif.enable = r_q.wctl[tecfd_pkg::ENABLE_BIT];
    assign wif.edge_sel = r_q.wctl[tecfd_pkg::EDGE_BIT];
    assign wif.tick = r_q.wctl[tecfd_pkg::WIDE_CLK_SEL_BIT] ? sub_tick : sysdiv_tick;  // RULE9
    assign wif.ev_src = (wif.mode == tecfd_pkg::MODE_EVENT_CMP) ? r_q.s2[1] : r_q.s2[3];
    assign wif.pin_src = r_q.s2[3];
    assign wif.preload = r_q.wpre;
    assign wif.preload_wr = r_q.wwr;
    always_comb begin
        r_d = r_q;
        psc_next = r_q.psc + 7'h01;
        // Each rate pulses when all lower prescaler bits roll over together
        case (r_q.nctl[2:0])  // RULE20 RULE21
            3'h0: ntick = 1'b1;
            3'h1: ntick = r_q.psc[0];
            3'h2: ntick = &r_q.psc[1:0];
            3'h3: ntick = &r_q.psc[2:0];
            3'h4: ntick = &r_q.psc[3:0];
            3'h5: ntick = &r_q.psc[4:0];
            3'h6: ntick = &r_q.psc[5:0];
            default: ntick = &r_q.psc[6:0];
        endcase
        sysdiv_tick = (r_q.div4 == tecfd_pkg::SYS_DIV4_COUNT);
        sub_tick = (r_q.subc == 12'(tecfd_pkg::SUB_DIV_CYCLES - 1));
        r_d.psc = psc_next;
        r_d.div4 = r_q.div4 + 2'h1;
        r_d.subc = sub_tick ? 12'h000 : r_q.subc + 12'h001;
        r_d.s1 = {port_a_bit5_pin_in, wide_count_input_pin_in, narrow_count_input_pin_in,
                  comparator_two_output_in, comparator_one_output_in};  // RULE25
        r_d.s2 = r_q.s1;
        r_d.pin5 = r_q.s2[4];
        r_d.nwr = 1'b0;
        r_d.wwr = 1'b0;
        wr = avs_write_in && r_q.ack;
        rd = avs_read_in && !r_q.ack;
        r_d.ack = rd || (avs_write_in && !r_q.ack);
        ctl_w = avs_writedata_in[7:0];
        pre_w = avs_writedata_in[15:0];
        if (wr && avs_byteenable_in[0]) begin
            if (avs_address_in == tecfd_pkg::ADDR_NARROW_CTRL) begin
                r_d.nctl = ctl_w & tecfd_pkg::NARROW_CTRL_MASK;
            end else if (avs_address_in == tecfd_pkg::ADDR_NARROW_PRELOAD) begin
                r_d.npre = ctl_w;
                r_d.nwr = 1'b1;
            end else if (avs_address_in == tecfd_pkg::ADDR_WIDE_CTRL) begin
                r_d.wctl = ctl_w & tecfd_pkg::WIDE_CTRL_MASK;
            end else if (avs_address_in == tecfd_pkg::ADDR_WIDE_PRELOAD) begin
                r_d.wpre[7:0] = pre_w[7:0];
                r_d.wwr = 1'b1;
            end else if (avs_address_in == tecfd_pkg::ADDR_INT_CTRL) begin
                r_d.intc = ctl_w[3:0];
            end else if (avs_address_in == tecfd_pkg::ADDR_MISC) begin
                r_d.misc = ctl_w[1:0];
            end else if (avs_address_in == tecfd_pkg::ADDR_PORT_A) begin
                r_d.pdat5 = ctl_w[0];
                r_d.pdir5 = ctl_w[1];
            end else if (avs_address_in == tecfd_pkg::ADDR_POWER) begin
                r_d.pdown = ctl_w[0];
            end
        end
        if (wr && avs_byteenable_in[1] && avs_address_in == tecfd_pkg::ADDR_WIDE_PRELOAD) begin
            r_d.wpre[15:8] = pre_w[15:8];
            r_d.wwr = 1'b1;
        end
        if (nif.stop_clr) begin
            r_d.nctl[tecfd_pkg::ENABLE_BIT] = 1'b0;  // RULE11
        end
        if (wif.stop_clr) begin
            r_d.wctl[tecfd_pkg::ENABLE_BIT] = 1'b0;
        end
        // Hardware set beats a same-cycle software clear
        if (nif.overflow) begin
            r_d.intc[tecfd_pkg::INT_NARROW_REQ_BIT] = 1'b1;  // RULE3
        end
        if (wif.overflow) begin
            r_d.intc[tecfd_pkg::INT_WIDE_REQ_BIT] = 1'b1;
        end
        nreq = r_d.intc[tecfd_pkg::INT_NARROW_REQ_BIT];
        wreq = r_d.intc[tecfd_pkg::INT_WIDE_REQ_BIT];
        r_d.nirq = nreq && r_d.intc[tecfd_pkg::INT_NARROW_EN_BIT];  // RULE4
        r_d.wirq = wreq && r_d.intc[tecfd_pkg::INT_WIDE_EN_BIT];
        r_d.wake = r_q.pdown && (nif.overflow || wif.overflow);  // RULE8
        ovf_sel = r_q.misc[tecfd_pkg::MISC_FD_SEL_BIT] ? wif.overflow : nif.overflow;  // RULE16 RULE22
        if (ovf_sel) begin
            r_d.fd = ~r_q.fd;  // RULE15
        end
        r_d.poe = r_q.pdir5;  // RULE18
        if (r_q.misc[tecfd_pkg::MISC_FD_EN_BIT]) begin
            r_d.pout = r_q.pdat5 & r_q.fd;  // RULE19
        end else begin
            r_d.pout = r_q.pdat5;  // RULE17
        end
        r_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (avs_address_in == tecfd_pkg::ADDR_NARROW_CTRL) begin
                r_d.rdata[7:0] = r_q.nctl;
            end else if (avs_address_in == tecfd_pkg::ADDR_NARROW_PRELOAD) begin
                r_d.rdata[7:0] = r_q.npre;
            end else if (avs_address_in == tecfd_pkg::ADDR_NARROW_COUNT) begin
                r_d.rdata[15:0] = nif.count;
            end else if (avs_address_in == tecfd_pkg::ADDR_WIDE_CTRL) begin
                r_d.rdata[7:0] = r_q.wctl;
            end else if (avs_address_in == tecfd_pkg::ADDR_WIDE_PRELOAD) begin
                r_d.rdata[15:0] = r_q.wpre;
            end else if (avs_address_in == tecfd_pkg::ADDR_WIDE_COUNT) begin
                r_d.rdata[15:0] = wif.count;
            end else if (avs_address_in == tecfd_pkg::ADDR_INT_CTRL) begin
                r_d.rdata[3:0] = r_q.intc;
            end else if (avs_address_in == tecfd_pkg::ADDR_MISC) begin
                r_d.rdata[1:0] = r_q.misc;
            end else if (avs_address_in == tecfd_pkg::ADDR_PORT_A) begin
                r_d.rdata[2:0] = {r_q.pin5, r_q.pdir5, r_q.pdat5};
            end else if (avs_address_in == tecfd_pkg::ADDR_POWER) begin
                r_d.rdata[0] = r_q.pdown;
            end
        end
        if (sys_rst_in) begin
            r_d = '0;
            r_d.nctl = tecfd_pkg::NARROW_CTRL_RESET;
            r_d.wctl = tecfd_pkg::WIDE_CTRL_RESET;
        end
    end
    always_ff @(posedge clock_in) begin
        r_q <= r_d;
    end
    assign avs_readdata_out = r_q.rdata;
    assign avs_waitrequest_out = ~r_q.ack;
    assign freq_divider_output_out = r_q.pout;
    assign freq_divider_output_oe_out = r_q.poe;
    assign narrow_irq_out = r_q.nirq;
    assign wide_irq_out = r_q.wirq;
    assign wakeup_out = r_q.wake;
endmodule
`default_nettype wire

// ### tb/tecfd_far.sv
// Purpose: far-side source of comparator and pin edges
// Assumes: paced by clock_in, one line pulsed at a time
// Notes: idle lines rest low; the chosen line rests at lvl_in
`timescale 1ns/1ps
`default_nettype none
module tecfd_far (
    input wire logic clock_in,     // clock
    input wire logic go_in,        // start a burst
    input wire logic [1:0] sel_in, // line to drive
    input wire logic lvl_in,       // rest level
    input wire logic [7:0] n_in,   // pulse count
    input wire logic [7:0] w_in,   // half period
    output logic busy_out,         // burst running
    output logic [3:0] line_out    // cmp1, cmp2, pin0, pin1
);
    int n = 0;
    int c = 0;
    assign busy_out = n != 0;
    always @(posedge clock_in) begin
        if (go_in && !busy_out) begin
            n <= n_in;
            c <= 0;
        end else if (busy_out) begin
            c <= (c == 2 * w_in - 1) ? 0 : c + 1;
            if (c == 2 * w_in - 1)
                n <= n - 1;
        end
    end
    always_comb begin
        line_out = 4'h0;
        line_out[sel_in] = (busy_out && c < w_in) ? !lvl_in : lvl_in;
    end
endmodule
`default_nettype wire

// ### tb/tecfd_chk.sv
// Purpose: port-level checks on the timer block
// Assumes: one clock, synchronous reset
// Notes: irq drops are only legal right after a register write
`timescale 1ns/1ps
`default_nettype none
module tecfd_chk (
    input wire logic clock_in,            // clock
    input wire logic sys_rst_in,          // reset
    input wire logic [3:0] avs_address_in, // address
    input wire logic avs_read_in,         // read
    input wire logic avs_write_in,        // write
    input wire logic [31:0] avs_readdata_out, // read data
    input wire logic avs_waitrequest_out, // stall
    input wire logic narrow_irq_out,      // narrow irq
    input wire logic wide_irq_out,        // wide irq
    input wire logic wakeup_out           // wake pulse
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_take;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ack;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    a_bus_answer: assert property (s_take |=> s_ack)
        else $error("no bus answer");
    a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("ack too long");
    a_rdata_idle: assert property (avs_waitrequest_out |-> avs_readdata_out == 32'h0)
        else $error("stale read data");
    a_unmapped_zero: assert property (s_take ##0 (avs_read_in && avs_address_in > 4'h9) |=> avs_readdata_out == 32'h0)
        else $error("unmapped read");
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> !narrow_irq_out && !wide_irq_out && avs_waitrequest_out)
        else $error("bad reset state");
    a_wake_pulse: assert property (wakeup_out |=> !wakeup_out)
        else $error("wake pulse too long");
    a_narrow_irq_hold: assert property ($fell(narrow_irq_out) |->
        $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3))
        else $error("narrow irq dropped");
    a_wide_irq_hold: assert property ($fell(wide_irq_out) |->
        $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3))
        else $error("wide irq dropped");
endmodule
bind tecfd_top tecfd_chk u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .narrow_irq_out(narrow_irq_out), .wide_irq_out(wide_irq_out),
    .wakeup_out(wakeup_out));
`default_nettype wire

// ### tb/testbench.sv
// Purpose: register-driven test of both counters and the divider pin
// Assumes: two-cycle bus accesses, far side from tecfd_far
// Notes: timed counts allow two counts of slack
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [3:0] NC = tecfd_pkg::ADDR_NARROW_CTRL;
    localparam logic [3:0] NP = tecfd_pkg::ADDR_NARROW_PRELOAD;
    localparam logic [3:0] NT = tecfd_pkg::ADDR_NARROW_COUNT;
    localparam logic [3:0] WC = tecfd_pkg::ADDR_WIDE_CTRL;
    localparam logic [3:0] IC = tecfd_pkg::ADDR_INT_CTRL;
    localparam logic [3:0] MS = tecfd_pkg::ADDR_MISC;
    localparam logic [3:0] PA = tecfd_pkg::ADDR_PORT_A;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, v, v0;
    logic waitreq, fd_out, fd_oe, irq0, irq1, wake, busy;
    logic go = 1'b0;
    logic lvl = 1'b0;
    logic ext = 1'b1;
    logic [1:0] sel = 2'h2;
    logic [7:0] npl = 8'h1;
    logic [7:0] wpl = 8'h1;
    logic [3:0] line, ac;
    wire pin = fd_oe ? fd_out : ext;
    int n_fail = 0;
    int num_checks = 0;
    int n_wake = 0;
    tecfd_top dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr), .avs_read_in(avs_rd),
        .avs_write_in(avs_wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .comparator_one_output_in(line[0]), .comparator_two_output_in(line[1]),
        .narrow_count_input_pin_in(line[2]), .wide_count_input_pin_in(line[3]), .port_a_bit5_pin_in(pin),
        .freq_divider_output_out(fd_out), .freq_divider_output_oe_out(fd_oe), .narrow_irq_out(irq0),
        .wide_irq_out(irq1), .wakeup_out(wake));
    tecfd_far far (.clock_in(clock_in), .go_in(go), .sel_in(sel), .lvl_in(lvl), .n_in(npl), .w_in(wpl),
        .busy_out(busy), .line_out(line));
    initial begin
        forever #5 clock_in = !clock_in;
    end
    always @(posedge clock_in) begin
        if (wake === 1'b1)
            n_wake++;
    end
    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            tally_and_finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if ((got - exp + 32'h2 <= 32'h4) !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        avs_rd <= !w;
        avs_wr <= w;
        addr <= a;
        wdata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (waitreq === 1'b0)
                break;
        end
        v = rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        bound(i, 20);
        @(posedge clock_in);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        cyc(1'b1, a, d);
    endtask
    task automatic rreg(input logic [3:0] a);
        cyc(1'b0, a, 32'h0);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clock_in);
    endtask
    task automatic burst(input logic [1:0] s, input logic [7:0] n, input logic [7:0] w);
        int i;
        sel <= s;
        npl <= n;
        wpl <= w;
        go <= 1'b1;
        @(posedge clock_in);
        go <= 1'b0;
        for (i = 0; i < 4000 && (i < 2 || busy); i++)
            @(posedge clock_in);
        bound(i, 4000);
        idle(6);
    endtask
    // Sets the line's rest level, reads the count
    task automatic step(input logic l, input logic [3:0] a, input logic [31:0] exp);
        lvl <= l;
        idle(8);
        rreg(a);
        chk(v, exp);
    endtask
    // Half period of the divider pin in clock cycles
    task automatic period(input int exp);
        int i, j;
        logic s;
        s = fd_out;
        for (i = 0; i < 100 && fd_out === s; i++)
            @(posedge clock_in);
        s = fd_out;
        for (j = 0; j < 100 && fd_out === s; j++)
            @(posedge clock_in);
        bound(i, 100);
        chk(j, exp);
    endtask
    initial begin
        repeat (6) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        rreg(NC); chk(v, {24'h0, tecfd_pkg::NARROW_CTRL_RESET});
        rreg(WC); chk(v, {24'h0, tecfd_pkg::WIDE_CTRL_RESET});
        rreg(MS); chk(v, 32'h0);
        rreg(4'hf); chk(v, 32'h0);
        for (int p = 0; p < 8; p++) begin
            wreg(NC, 32'h80 | p);
            wreg(NP, 32'h0);
            rreg(NT); chk(v, 32'h0);
            wreg(NC, 32'h90 | p);
            idle(200);
            rreg(NC); chk(v, 32'h90 | p);
            wreg(NC, 32'h80 | p);
            rreg(NT); chk_near(v, 206 >> p);
        end
        v0 = v;
        idle(30);
        rreg(NT); chk(v, v0);
        wreg(NP, 32'hfc);
        wreg(IC, 32'h3);
        wreg(MS, 32'h1);
        wreg(PA, 32'h3);
        wreg(NC, 32'h90);
        period(4);
        chk(irq0, 1'b1);
        wreg(IC, 32'h6);
        idle(3);
        chk(irq0, 1'b0);
        rreg(IC); chk(v & 32'h4, 32'h4);
        wreg(PA, 32'h2);
        idle(4); chk({fd_oe, fd_out}, 2'b10);
        idle(3); chk({fd_oe, fd_out}, 2'b10);
        wreg(MS, 32'h0);
        wreg(PA, 32'h3);
        idle(4); chk({fd_oe, fd_out}, 2'b11);
        wreg(PA, 32'h1);
        idle(4); chk(fd_oe, 1'b0);
        rreg(PA); chk(v, 32'h5);
        wreg(NC, 32'h80);
        wreg(tecfd_pkg::ADDR_WIDE_PRELOAD, 32'hfffe);
        wreg(WC, 32'h90);
        wreg(MS, 32'h3);
        wreg(PA, 32'h3);
        period(8);
        chk(irq1, 1'b1);
        wreg(IC, 32'h0);
        idle(3);
        chk(irq1, 1'b0);
        wreg(WC, 32'h80);
        wreg(WC + 4'h1, 32'h0);
        wreg(WC, 32'hb0);
        idle(6100);
        rreg(WC + 4'h2); chk_near(v, 2);
        for (int k = 0; k < 4; k++) begin
            ac = (k & 1) ? WC : NC;
            wreg(ac, ((k >> 1) << 6) | 7);
            wreg(ac + 4'h1, 32'h0);
            wreg(ac, ((k >> 1) << 6) | 32'h17);
            sel <= k;
            step(1'b1, ac + 4'h2, 32'h1);
            lvl <= 1'b0;
            burst(k, 4, 3);
            rreg(ac + 4'h2); chk(v, 32'h5);
            wreg(ac, ((k >> 1) << 6) | 32'h1f);
            step(1'b1, ac + 4'h2, 32'h5);
            step(1'b0, ac + 4'h2, 32'h6);
            wreg(ac, 32'h0);
        end
        wreg(tecfd_pkg::ADDR_POWER, 32'h1);
        wreg(NC, 32'h40);
        wreg(NP, 32'hfe);
        wreg(NC, 32'h50);
        burst(2, 2, 3);
        chk(n_wake, 1);
        rreg(NT); chk(v, 32'hfe);
        for (int e = 0; e < 2; e++) begin
            wreg(NC, 32'hc0 | (e << 3));
            wreg(NP, 32'h0);
            wreg(NC, 32'hd0 | (e << 3));
            step(e, NT, 32'h0);
            step(!e, NT, 32'h0);
            burst(2, 1, 60);
            rreg(NT); chk_near(v, 60);
            v0 = v;
            rreg(NC); chk(v, 32'hc0 | (e << 3));
            burst(2, 1, 20);
            rreg(NT); chk(v, v0);
        end
        tally_and_finish;
    end
    initial begin
        repeat (90000) @(posedge clock_in);
        n_fail++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
